/* bench/test_virt_watch_perf_ctl_fields.sv */
// Purpose: Self-checking bench for the watch-high and perf-control field bank
// Assumes: Two counters, both fields implemented, inputs driven by NBA at rising edges, except flag, driven 1 ns after one
// Notes:   Bench models hold the expected register contents
`timescale 1ns/1ps
module test_virt_watch_perf_ctl_fields;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        sw_root = 1'b0;
    logic        flag = 1'b0;
    logic        guest_mode = 1'b0;
    logic        exception_level_count_en = 1'b0;
    logic        erl = 1'b0;
    logic        debug_mode = 1'b0;
    logic [1:0]  perf_event = 2'h0;
    logic [31:0] rdata;
    logic [1:0]  perf_counter_inc;
    logic [31:0] wh_m = 32'h0;
    logic [31:0] pc_m [2] = '{32'h0, 32'h0};
    logic [7:0]  a_tab [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h40};
    logic [7:0]  a;
    logic [31:0] d;
    logic        r;
    logic [1:0]  e;
    int          seed = 9731;
    int          n_fail = 0;
    int          checks_done = 0;
    always #10 ref_clk = ~ref_clk;
    vwp_regs #(.NCTR(2), .WM_IMPL(1'b1), .EC_IMPL(1'b1)) i_vwp_regs (.ref_clk(ref_clk), .rstn(rstn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sw_root(sw_root), .extended_address_space_id_flag(flag),
        .guest_mode(guest_mode), .exception_level_count_en(exception_level_count_en), .erl(erl), .debug_mode(debug_mode), .perf_event(perf_event),
        .perf_counter_inc(perf_counter_inc));
    function automatic logic [31:0] wh_mask(input logic f, input logic rt);
        return 32'h4000_0ff8 | (rt ? 32'h3000_0000 : 32'h0) | (f ? 32'h03ff_0000 : 32'h00ff_0000);
    endfunction : wh_mask
    function automatic logic [31:0] pc_mask(input logic rt);
        return 32'h0000_ffff | (rt ? 32'h0180_0000 : 32'h0);
    endfunction : pc_mask
    function automatic logic exp_inc(input logic [1:0] ec, input logic g, input logic iv);
        return (ec == 2'h0) ? !g : (ec == 2'h1) ? (g & iv) : (ec == 2'h2) ? (g & !iv) : g;
    endfunction : exp_inc
    function automatic logic [31:0] exp_rd(input logic [7:0] ad, input logic rt);
        if (ad == 8'h00)
            return wh_m & wh_mask(flag, rt);
        if (ad == 8'h04 || ad == 8'h08)
            return pc_m[ad[3]] & pc_mask(rt);
        return 32'h0;
    endfunction : exp_rd
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checks_done++;
        if (g !== x)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] ad, input logic [31:0] dt, input logic rt);
        logic [31:0] m;
        @(posedge ref_clk);
        addr <= ad;
        wdata <= dt;
        sw_root <= rt;
        wr <= 1'b1;
        m = (ad == 8'h00) ? wh_mask(flag, rt) : pc_mask(rt);
        if (ad == 8'h00)
            wh_m = (dt & m) | (wh_m & ~m & 32'h3000_0000);
        else if (ad == 8'h04 || ad == 8'h08)
            pc_m[ad[3]] = (dt & m) | (pc_m[ad[3]] & ~m & 32'h0180_0000);
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] ad, input logic rt);
        @(posedge ref_clk);
        addr <= ad;
        sw_root <= rt;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp_rd(ad, rt));
    endtask : rd_chk
    task automatic print_verdict;
        if (n_fail == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict
    initial
    begin
        #1_000_000;
        n_fail++;
        print_verdict();
    end
    initial
    begin
        repeat (12) @(posedge ref_clk);
        rstn <= 1'b1;
        for (int i = 0; i < 3; i++) rd_chk(a_tab[i], 1'b1);
        for (int k = 0; k < 200; k++)
        begin
            a = a_tab[$unsigned($random(seed)) % 5];
            d = (k < 4) ? 32'hffff_ffff : $random(seed);
            r = (k < 4) ? k[0] : $random(seed);
            flag <= (k < 4) ? k[1] : $random(seed);
            wr_reg(a, d, r);
            rd_chk(a, $random(seed));
        end
        @(posedge ref_clk);
        addr    <= 8'h00;
        wdata   <= 32'h3000_0000;
        sw_root <= 1'b1;
        wr      <= 1'b1;
        wh_m = 32'h3000_0000 & wh_mask(flag, 1'b1);
        @(posedge ref_clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp_rd(8'h00, 1'b1));
        for (int i = 0; i < 2; i++)
            for (int ec = 0; ec < 4; ec++)
            begin
                wr_reg(8'h04 + 8'(4 * i), 32'(ec) << 23, 1'b1);
                rd_chk(8'h04 + 8'(4 * i), 1'b1);
                repeat (12)
                begin
                    @(posedge ref_clk);
                    {guest_mode, exception_level_count_en, erl, debug_mode, perf_event} <= 6'($random(seed));
                    @(posedge ref_clk);
                    #1;
                    for (int j = 0; j < 2; j++) e[j] = perf_event[j] & exp_inc(pc_m[j][24:23], guest_mode,
                        guest_mode & (exception_level_count_en | erl | debug_mode));
                    chk({30'h0, perf_counter_inc}, {30'h0, e});
                end
            end
        print_verdict();
    end
endmodule : test_virt_watch_perf_ctl_fields

/* hw/vwp_pkg.sv */
// Purpose: Constants for the watch-high and performance-control field bank
// Assumes: Byte-addressed register port, one aligned 32-bit word per register
// Notes:   Field positions follow the register layouts of the block
package vwp_pkg;
    localparam int          ADDR_W        = 8;
    localparam logic [7:0]  OFS_WATCH_HI  = 8'h00;
    localparam logic [7:0]  OFS_PERF_BASE = 8'h04;
    localparam int          WH_G_BIT      = 30;
    localparam int          WH_WM_LSB     = 28;
    localparam int          WH_ADDRESS_SPACE_ID_LSB   = 16;
    localparam int          WH_MASK_LSB   = 3;
    localparam int          ADDRESS_SPACE_ID_W_EXT    = 10;
    localparam int          ADDRESS_SPACE_ID_W_BASE   = 8;
    localparam int          PC_EC_LSB     = 23;
    localparam int          PC_LOW_W      = 16;
    localparam logic [1:0]  WM_RESET      = 2'h0;
    localparam logic [1:0]  EC_RESET      = 2'h0;
    localparam logic [1:0]  EC_ROOT       = 2'h0;
    localparam logic [1:0]  EC_ROOT_INTV  = 2'h1;
    localparam logic [1:0]  EC_GUEST      = 2'h2;
    localparam logic [1:0]  EC_GUEST_INTV = 2'h3;
endpackage : vwp_pkg

/* hw/vwp_regs.sv */
// Purpose: Watch-high and performance-counter-control fields added for virtualization
// Assumes: Accesses are privileged register moves; sw_root tells the context of the access
// Notes:   Counter increment itself lives elsewhere; this block qualifies events only
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module vwp_regs #(
    parameter int NCTR    = 2,
    parameter bit WM_IMPL = 1'b1,
    parameter bit EC_IMPL = 1'b1
) (
    // Clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        rstn,
    // Register port
    input  wire logic [vwp_pkg::ADDR_W-1:0]  addr,
    input  wire logic [31:0]                 wdata,
    input  wire logic                        wr,
    input  wire logic                        rd,
    output logic      [31:0]                 rdata,
    // Access context and configuration
    input  wire logic                        sw_root,
    input  wire logic                        extended_address_space_id_flag,
    // Execution context of the core
    input  wire logic                        guest_mode,
    input  wire logic                        exception_level_count_en,
    input  wire logic                        erl,
    input  wire logic                        debug_mode,
    // Events and qualified increments
    input  wire logic [NCTR-1:0]             perf_event,
    output logic      [NCTR-1:0]             perf_counter_inc
);
    // Refuse counter counts outside 1 to 15
    if (NCTR < 1 || NCTR > 15)
    begin : g_bad_nctr
        $error("NCTR must be 1 to 15");
    end

    typedef struct packed {
        logic [1:0]                  ec;
        logic [vwp_pkg::PC_LOW_W-1:0] low;
    } vwp_pc_t;

    typedef struct packed {
        logic                          wh_g;
        logic [1:0]                    watch_root_mgmt;
        logic [vwp_pkg::ADDRESS_SPACE_ID_W_EXT-1:0] address_space_id;
        logic [8:0]                    wh_mask;
        vwp_pc_t [NCTR-1:0]            pc;
        logic [31:0]                   rdata;
        logic [NCTR-1:0]               inc;
    } vwp_state_t;

    vwp_state_t st;
    vwp_state_t next_st;

    // Decode the performance-control index; returns NCTR when no match
    function automatic int pc_index(input logic [vwp_pkg::ADDR_W-1:0] a);
        int k;
        k = NCTR;
        for (int i = 0; i < NCTR; i++)
            if (a == vwp_pkg::OFS_PERF_BASE + vwp_pkg::ADDR_W'(4 * i))
                k = i;
        return k;
    endfunction : pc_index

    // Event qualification by the selected context
    function automatic logic ctx_hit(input logic [1:0] sel, input logic gm, input logic intv);
        logic h;
        h = 1'b0;
        case (sel)
            vwp_pkg::EC_ROOT:       h = !gm;
            vwp_pkg::EC_ROOT_INTV:  h = gm && intv;
            vwp_pkg::EC_GUEST:      h = gm && !intv;
            vwp_pkg::EC_GUEST_INTV: h = gm;
            default:                h = 1'b0;
        endcase
        return h;
    endfunction : ctx_hit

    logic intv;
    assign intv = guest_mode && (exception_level_count_en || erl || debug_mode);

    always_comb
    begin
        int k;
        logic [9:0] address_space_id_rd;
        k = pc_index(addr);
        address_space_id_rd = '0;
        next_st = st;
        next_st.rdata = 32'h0;
        if (wr && addr == vwp_pkg::OFS_WATCH_HI)
        begin
            next_st.wh_g = wdata[vwp_pkg::WH_G_BIT];
            next_st.wh_mask = wdata[vwp_pkg::WH_MASK_LSB +: 9];
            if (extended_address_space_id_flag)
                next_st.address_space_id = wdata[vwp_pkg::WH_ADDRESS_SPACE_ID_LSB +: vwp_pkg::ADDRESS_SPACE_ID_W_EXT];
            else
                next_st.address_space_id = {2'h0, wdata[vwp_pkg::WH_ADDRESS_SPACE_ID_LSB +: vwp_pkg::ADDRESS_SPACE_ID_W_BASE]};
            if (sw_root && WM_IMPL)
                next_st.watch_root_mgmt = wdata[vwp_pkg::WH_WM_LSB +: 2];
        end
        if (wr && k < NCTR)
        begin
            next_st.pc[k].low = wdata[vwp_pkg::PC_LOW_W-1:0];
            if (sw_root && EC_IMPL)
                next_st.pc[k].ec = wdata[vwp_pkg::PC_EC_LSB +: 2];
        end
        if (rd && addr == vwp_pkg::OFS_WATCH_HI)
        begin
            address_space_id_rd = extended_address_space_id_flag ? st.address_space_id
                                         : {2'h0, st.address_space_id[vwp_pkg::ADDRESS_SPACE_ID_W_BASE-1:0]};
            next_st.rdata[vwp_pkg::WH_G_BIT] = st.wh_g;
            next_st.rdata[vwp_pkg::WH_ADDRESS_SPACE_ID_LSB +: vwp_pkg::ADDRESS_SPACE_ID_W_EXT] = address_space_id_rd;
            next_st.rdata[vwp_pkg::WH_MASK_LSB +: 9] = st.wh_mask;
            if (sw_root)
                next_st.rdata[vwp_pkg::WH_WM_LSB +: 2] = st.watch_root_mgmt;
        end
        if (rd && k < NCTR)
        begin
            next_st.rdata[vwp_pkg::PC_LOW_W-1:0] = st.pc[k].low;
            if (sw_root)
                next_st.rdata[vwp_pkg::PC_EC_LSB +: 2] = st.pc[k].ec;
        end
        for (int i = 0; i < NCTR; i++)
            next_st.inc[i] = perf_event[i] && ctx_hit(st.pc[i].ec, guest_mode, intv);
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            st <= '0;
            st.watch_root_mgmt <= vwp_pkg::WM_RESET;
            for (int i = 0; i < NCTR; i++)
                st.pc[i].ec <= vwp_pkg::EC_RESET;
        end
        else
            st <= next_st;
    end

    assign rdata = st.rdata;
    assign perf_counter_inc = st.inc;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    AST_ADDRESS_SPACE_ID_WIDE: assert property ((wr && addr == vwp_pkg::OFS_WATCH_HI && extended_address_space_id_flag)
        |=> st.address_space_id == $past(wdata[25:16])) else $error("address_space_id not 10 bits");
    AST_ADDRESS_SPACE_ID_NARROW: assert property ((rd && addr == vwp_pkg::OFS_WATCH_HI && !extended_address_space_id_flag)
        |=> rdata[25:24] == 2'h0) else $error("address_space_id wider than 8 bits");
    AST_WM_RESET: assert property (disable iff (1'b0) !rstn |=> st.watch_root_mgmt == 2'h0)
        else $error("watch mgmt not reset");
    AST_WM_GUEST_ZERO: assert property ((rd && addr == vwp_pkg::OFS_WATCH_HI && !sw_root)
        |=> rdata[29:28] == 2'h0) else $error("watch mgmt visible to guest");
    AST_WM_DETECT: assert property ((wr && addr == vwp_pkg::OFS_WATCH_HI && sw_root) ##1
        (rd && addr == vwp_pkg::OFS_WATCH_HI && sw_root && !wr)
        |=> rdata[29:28] == (WM_IMPL ? $past(wdata[29:28], 2) : 2'h0)) else $error("watch mgmt readback wrong");
    AST_EC_WRITE: assert property ((wr && addr == vwp_pkg::OFS_PERF_BASE && sw_root)
        |=> st.pc[0].ec == (EC_IMPL ? $past(wdata[24:23]) : 2'h0)) else $error("event context not stored");
    AST_EC_GUEST_HOLD: assert property ((wr && !sw_root) |=> $stable(st.pc[0].ec))
        else $error("guest changed event context");
    AST_EC_ABSENT: assert property (!EC_IMPL |-> st.pc[0].ec == 2'h0)
        else $error("unsupported event context nonzero");
    AST_ROOT_ONLY: assert property ((perf_event[0] && st.pc[0].ec == 2'h0 && guest_mode)
        |=> !perf_counter_inc[0]) else $error("guest event counted in root selection");
    AST_GUEST_CNT: assert property ((perf_event[0] && st.pc[0].ec == 2'h2 && guest_mode && !intv)
        |=> perf_counter_inc[0]) else $error("guest event missed");
    AST_QUALIFY: assert property (perf_counter_inc[0]
        |-> $past(perf_event[0])) else $error("increment without event");
    AST_GUEST_READ: assert property ((rd && addr == vwp_pkg::OFS_PERF_BASE && !sw_root)
        |=> rdata[24:23] == 2'h0) else $error("event context visible to guest");

    // Watch-high field storage
    AST_ADDRESS_SPACE_ID_CLEAR_UPPER: assert property ((wr && addr == vwp_pkg::OFS_WATCH_HI && !extended_address_space_id_flag)
        |=> st.address_space_id[9:8] == 2'h0) else $error("address_space_id upper bits kept");
    AST_WM_ROOT_WRITE: assert property ((wr && addr == vwp_pkg::OFS_WATCH_HI && sw_root)
        |=> st.watch_root_mgmt == (WM_IMPL ? $past(wdata[29:28]) : 2'h0)) else $error("watch mgmt not stored");
    AST_WM_GUEST_HOLD: assert property ((wr && addr == vwp_pkg::OFS_WATCH_HI && !sw_root)
        |=> $stable(st.watch_root_mgmt)) else $error("guest changed watch mgmt");

    // Event-context storage and readback
    AST_EC_RESET: assert property (disable iff (1'b0) !rstn
        |=> st.pc[0].ec == 2'h0 && rdata == 32'h0) else $error("event context not reset");
    AST_EC_READ_ROOT: assert property ((rd && addr == vwp_pkg::OFS_PERF_BASE && sw_root && !wr)
        |=> rdata[24:23] == $past(st.pc[0].ec)) else $error("event context readback wrong");
    AST_EC_GUEST_READ1: assert property ((rd && addr == 8'h08 && !sw_root)
        |=> rdata[24:23] == 2'h0) else $error("second event context visible to guest");

    // Read data stands only in the cycle after a read
    AST_RDATA_IDLE: assert property (!rd
        |=> rdata == 32'h0) else $error("read data without read");

    // Event qualification per selection
    AST_ROOT_CNT: assert property ((perf_event[0] && st.pc[0].ec == 2'h0 && !guest_mode)
        |=> perf_counter_inc[0]) else $error("root event missed");
    AST_ROOT_INTV_CNT: assert property ((perf_event[0] && st.pc[0].ec == 2'h1 && intv)
        |=> perf_counter_inc[0]) else $error("root intervention event missed");
    AST_GUEST_INTV_CNT: assert property ((perf_event[0] && st.pc[0].ec == 2'h3 && guest_mode)
        |=> perf_counter_inc[0]) else $error("guest plus intervention event missed");
    AST_INC_IDLE: assert property (!perf_event[0]
        |=> !perf_counter_inc[0]) else $error("increment without event");
    AST_INTV_ROOT_DROP: assert property ((perf_event[0] && st.pc[0].ec == 2'h1 && !guest_mode)
        |=> !perf_counter_inc[0]) else $error("root event counted as intervention");
endmodule : vwp_regs
